// File: hw/rf_pkg.sv
package rf_pkg;
  // process data layout
  localparam int PNUM_W     = 4;
  localparam int DATA_W     = 25;
  localparam int NUM_PARAMS = 16;
  localparam int CH_W       = 32;
  localparam int ST_W       = 16;
  localparam int CH_DATA_HI = 24;
  localparam int CH_PNUM_LO = 25;
  localparam int CH_PNUM_HI = 28;
  localparam int CH_ZERO    = 30;
  localparam int CH_ENOP    = 31;
  localparam int ST_CODE_LO = 9;
  localparam int ST_CODE_HI = 12;
  localparam int ST_PARAM_BIT = 14;
  localparam int ST_INVALID   = 15;

  localparam logic [3:0] SENSOR_STATE_WORD_OFS = 4'h0;

  // parameter numbers
  localparam logic [3:0] PN_NONE      = 4'h0;
  localparam logic [3:0] PN_RES       = 4'h1;
  localparam logic [3:0] PN_LASER_OFF = 4'h2;
  localparam logic [3:0] PN_LASER_ON  = 4'h3;
  localparam logic [3:0] PN_PRESET    = 4'h4;
  localparam logic [3:0] PN_AUTO_OFF  = 4'h5;
  localparam logic [3:0] PN_UNDEF6    = 4'h6;
  localparam logic [3:0] PN_UNDEF7    = 4'h7;
  localparam logic [3:0] PN_COUNT_DIR = 4'h8;
  localparam logic [3:0] PN_SPEED     = 4'h9;
  localparam logic [3:0] PN_BEAM_ERR  = 4'hA;
  localparam logic [3:0] PN_UNDEFB    = 4'hB;
  localparam logic [3:0] PN_EXT_IN    = 4'hC;
  localparam logic [3:0] PN_CLR_PRE   = 4'hD;
  localparam logic [3:0] PN_EXT_OUT   = 4'hE;
  localparam logic [3:0] PN_SAVE      = 4'hF;

  // largest legal data value per parameter, plus the all-zero and all-ones data words
  localparam logic [24:0] RES_MAX     = 25'h000_0005;
  localparam logic [24:0] FLAG_MAX    = 25'h000_0001;
  localparam logic [24:0] SPEED_MAX   = 25'h000_00C8;
  localparam logic [24:0] BEAM_MAX    = 25'h000_0002;
  localparam logic [24:0] EXT_IN_MAX  = 25'h000_0003;
  localparam logic [24:0] EXT_OUT_MAX = 25'h000_0006;
  localparam logic [24:0] DATA_ZERO   = 25'h000_0000;
  localparam logic [24:0] DATA_ONES   = 25'h1FF_FFFF;

  // beam interruption modes and external input functions
  localparam logic [1:0] BEAM_NULL  = 2'h0;
  localparam logic [1:0] BEAM_ONES  = 2'h1;
  localparam logic [1:0] EXT_PRESET = 2'h1;
  localparam logic [1:0] EXT_LOFF   = 2'h2;
  localparam logic [1:0] EXT_QUIT   = 2'h3;

  // malfunction codes
  localparam logic [3:0] MF_NONE      = 4'h0;
  localparam logic [3:0] MF_BAD_PARAM = 4'h1;
  localparam logic [3:0] MF_HW        = 4'h3;
  localparam logic [3:0] MF_INT_WARN  = 4'h9;
  localparam logic [3:0] MF_LASER_OFF = 4'hA;
  localparam logic [3:0] MF_INT_ERR   = 4'hC;
  localparam logic [3:0] MF_SPEED     = 4'hD;
  localparam logic [3:0] MF_TEMP      = 4'hE;
  localparam logic [3:0] MF_JUMP      = 4'hF;

  // timing
  localparam int    CLK_PERIOD_NS    = 50;
  localparam longint CLK_HZ          = 20_000_000;
  localparam int    ACK_TIME_NS      = 1000;
  localparam int    ACK_CYCLES       = ACK_TIME_NS / CLK_PERIOD_NS;
  localparam int    IDLE_OFF_MIN     = 15;
  localparam longint IDLE_OFF_CYCLES = longint'(IDLE_OFF_MIN) * 60 * CLK_HZ;
  localparam int    IDLE_CNT_W       = 35;

  typedef enum logic [4:0] {
    ST_OPER  = 5'b0_0001,
    ST_PROC  = 5'b0_0010,
    ST_PARAM = 5'b0_0100,
    ST_APPLY = 5'b0_1000,
    ST_MALF  = 5'b1_0000
  } dev_state_t;

  typedef struct packed {
    logic [2:0] resolution;
    logic       laser_on;
    logic [24:0] preset;
    logic       auto_off;
    logic       count_down;
    logic [7:0] speed_limit;
    logic [1:0] beam_mode;
    logic [1:0] ext_in_fn;
    logic       clear_preset;
    logic [2:0] ext_out_fn;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    resolution:   3'h1,
    laser_on:     1'b1,
    preset:       25'h000_0000,
    auto_off:     1'b0,
    count_down:   1'b0,
    speed_limit:  8'h00,
    beam_mode:    2'h0,
    ext_in_fn:    2'h0,
    clear_preset: 1'b0,
    ext_out_fn:   3'h0
  };

  typedef struct packed {
    logic hw_fail;
    logic temp_fail;
    logic beam_lost;
    logic speed_fail;
    logic jump_fail;
    logic int_warn;
  } meas_flags_t;
endpackage : rf_pkg

// File: hw/pending_param_ram.sv
`timescale 1ns/1ps
// pending parameter values, one word per parameter number
module pending_param_ram #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_i,
  input  wire logic             en_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);
  if (DEPTH > (1 << AW) || WIDTH < 1) $error("pending_param_ram: bad geometry");

  logic [WIDTH-1:0] mem [DEPTH];

  // contents need no reset: a dirty bit guards every read
  always_ff @(posedge clk_i) begin
    if (en_i && wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule : pending_param_ram

// File: hw/pd_cmd_decode.sv
`timescale 1ns/1ps
// registers each new control word and finds the edge commands in it
module pd_cmd_decode (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        en_i,
  input  wire logic [31:0] pd_out_i,
  input  wire logic        pd_out_valid_i,
  output logic      [3:0]  pnum_o,
  output logic      [24:0] data_o,
  output logic             fresh_o,
  output logic             enable_op_o,
  output logic             zero_rise_o
);
  logic enop_q;
  logic zero_q;
  logic [3:0] in_pnum;

  assign in_pnum = pd_out_i[rf_pkg::CH_PNUM_HI:rf_pkg::CH_PNUM_LO];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pnum_o      <= 4'h0;
      data_o      <= 25'h000_0000;
      fresh_o     <= 1'b0;
      enable_op_o <= 1'b0;
      zero_rise_o <= 1'b0;
      enop_q      <= 1'b0;
      zero_q      <= 1'b0;
    end else if (en_i) begin
      fresh_o     <= pd_out_valid_i;
      enable_op_o <= 1'b0;
      zero_rise_o <= 1'b0;
      if (pd_out_valid_i) begin
        pnum_o <= in_pnum;
        data_o <= pd_out_i[rf_pkg::CH_DATA_HI:0];
        enop_q <= pd_out_i[rf_pkg::CH_ENOP];
        zero_q <= pd_out_i[rf_pkg::CH_ZERO];
        enable_op_o <= pd_out_i[rf_pkg::CH_ENOP] && !enop_q
                       && !pd_out_i[rf_pkg::CH_ZERO] && in_pnum == rf_pkg::PN_NONE;
        zero_rise_o <= pd_out_i[rf_pkg::CH_ZERO] && !zero_q;
      end
    end
  end
endmodule : pd_cmd_decode

// File: hw/rangefinder_param_status_handshake.sv
`timescale 1ns/1ps
// Notes on behaviour
// - status bits 15:14 give state: 00 operation, 11 parameterization, 10 malfunction.
// - status bits 9..15 sit on channel bits 25..31; bits 0..8 reserved.
// - status bits 9..12 echo last parameter number, or malfunction code.
// - nonzero parameter number on bits 9..12 starts parameterization.
// - accepted parameter moves to parameterization and echoes its number.
// - new parameters stay pending until enable-operation applies them.
// - unappliable pending parameters on enable-operation give malfunction state.
// - parameter 1 sets resolution, codes 0 to 5.
// - parameter 2 switches laser off, parameter 3 switches it on.
// - parameter 5 enables laser switch-off after 15 idle bus minutes.
// - parameter 8 selects rising or falling count with distance.
// - parameter 9 sets speed limit 0 to 200 in 0.1 m/s.
// - parameter 10 picks beam-loss output: zero, all ones, last valid.
// - parameter 12 selects external input function 0 to 3.
// - parameter 13 value 1 clears the stored preset.
// - parameter 14 selects external output source 0 to 6.
// - parameter 15 saves parameters; its data must be zero.
// - malfunction codes 0 none, 1 bad parameters, 3 hardware error.
// - codes 9 intensity warning, 10 laser off, 12 intensity error.
// - codes 13 speed check, 14 temperature, 15 position jump.
// - enable-operation is bit 15 rising with bit 14 clear and number zero.
// - rising channel bit 30 loads preset unless clear-preset is set.
module rangefinder_param_status_handshake #(
  parameter int                ACK_CYCLES      = rf_pkg::ACK_CYCLES,
  parameter logic [34:0]       IDLE_OFF_CYCLES = 35'(rf_pkg::IDLE_OFF_CYCLES)
) (
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  input  wire logic               en_i,
  input  wire logic [31:0]        pd_out_i,
  input  wire logic               pd_out_valid_i,
  input  wire logic [24:0]        position_i,
  input  wire rf_pkg::meas_flags_t meas_i,
  input  wire logic               ext_in_i,
  output logic      [31:0]        pd_in_o,
  output logic      [15:0]        sensor_state_word_o,
  output rf_pkg::cfg_t            cfg_o,
  output logic                    laser_en_o,
  output logic                    preset_load_o,
  output logic                    preset_clear_o,
  output logic                    save_req_o
);
  if (ACK_CYCLES < 1 || ACK_CYCLES > 65535) $error("ACK_CYCLES out of range");
  if (IDLE_OFF_CYCLES == 35'h0_0000_0000) $error("IDLE_OFF_CYCLES must be nonzero");

  rf_pkg::dev_state_t state;
  logic [3:0]  cw_pnum;
  logic [24:0] cw_data;
  logic        cw_fresh;
  logic        enable_op;
  logic        zero_rise;
  logic [3:0]  echo_num;
  logic [24:0] echo_data;
  logic [3:0]  acc_num;
  logic [24:0] acc_data;
  logic [15:0] ack_cnt;
  logic [15:0] dirty;
  logic        bad_param;
  logic [3:0]  malf_code;
  logic [4:0]  apply_idx;
  logic [3:0]  apply_idx_d;
  logic        apply_vld;
  logic [24:0] rd_data;
  logic        accept;
  logic [3:0]  live_code;
  logic [34:0] idle_cnt;
  logic        ext_q;
  logic        ext_rise;
  logic [24:0] last_pos;
  logic        applying;

  pd_cmd_decode u_decode (
    .clk_i          (clk_i),
    .arst_n_i       (arst_n_i),
    .en_i           (en_i),
    .pd_out_i       (pd_out_i),
    .pd_out_valid_i (pd_out_valid_i),
    .pnum_o         (cw_pnum),
    .data_o         (cw_data),
    .fresh_o        (cw_fresh),
    .enable_op_o    (enable_op),
    .zero_rise_o    (zero_rise)
  );

  pending_param_ram #(
    .WIDTH (rf_pkg::DATA_W),
    .DEPTH (rf_pkg::NUM_PARAMS),
    .AW    (rf_pkg::PNUM_W)
  ) u_pending (
    .clk_i     (clk_i),
    .en_i      (en_i),
    .wr_en_i   (accept),
    .wr_addr_i (cw_pnum),
    .wr_data_i (cw_data),
    .rd_addr_i (apply_idx[3:0]),
    .rd_data_o (rd_data)
  );

  function automatic logic param_ok(input logic [3:0] pn, input logic [24:0] d);
    case (pn)
      rf_pkg::PN_RES:       param_ok = d <= rf_pkg::RES_MAX;
      rf_pkg::PN_AUTO_OFF,
      rf_pkg::PN_COUNT_DIR,
      rf_pkg::PN_CLR_PRE:   param_ok = d <= rf_pkg::FLAG_MAX;
      rf_pkg::PN_SPEED:     param_ok = d <= rf_pkg::SPEED_MAX;
      rf_pkg::PN_BEAM_ERR:  param_ok = d <= rf_pkg::BEAM_MAX;
      rf_pkg::PN_EXT_IN:    param_ok = d <= rf_pkg::EXT_IN_MAX;
      rf_pkg::PN_EXT_OUT:   param_ok = d <= rf_pkg::EXT_OUT_MAX;
      rf_pkg::PN_SAVE:      param_ok = d == rf_pkg::DATA_ZERO;
      rf_pkg::PN_UNDEF6,
      rf_pkg::PN_UNDEF7,
      rf_pkg::PN_UNDEFB:    param_ok = 1'b0;
      default:              param_ok = 1'b1;
    endcase
  endfunction : param_ok

  // priority: hardware first, warnings last
  function automatic logic [3:0] fault_code(input rf_pkg::meas_flags_t m, input logic lon);
    if (m.hw_fail)         fault_code = rf_pkg::MF_HW;
    else if (m.temp_fail)  fault_code = rf_pkg::MF_TEMP;
    else if (m.beam_lost)  fault_code = rf_pkg::MF_INT_ERR;
    else if (m.speed_fail) fault_code = rf_pkg::MF_SPEED;
    else if (m.jump_fail)  fault_code = rf_pkg::MF_JUMP;
    else if (!lon)         fault_code = rf_pkg::MF_LASER_OFF;
    else if (m.int_warn)   fault_code = rf_pkg::MF_INT_WARN;
    else                   fault_code = rf_pkg::MF_NONE;
  endfunction : fault_code

  assign live_code = fault_code(meas_i, laser_en_o);
  assign ext_rise  = ext_in_i && !ext_q;
  // a number already echoed is not taken again while parameterizing
  assign accept = cw_fresh && cw_pnum != rf_pkg::PN_NONE && (
                  state == rf_pkg::ST_OPER || state == rf_pkg::ST_MALF ||
                  (state == rf_pkg::ST_PARAM && cw_pnum != echo_num));
  assign applying = apply_vld && dirty[apply_idx_d];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state     <= rf_pkg::ST_OPER;
      ack_cnt   <= 16'h0000;
      acc_num   <= 4'h0;
      acc_data  <= 25'h000_0000;
      echo_num  <= 4'h0;
      echo_data <= 25'h000_0000;
      malf_code <= 4'h0;
      apply_idx <= 5'h00;
    end else if (en_i) begin
      case (state)
        rf_pkg::ST_OPER, rf_pkg::ST_MALF, rf_pkg::ST_PARAM: begin
          if (accept) begin
            state    <= rf_pkg::ST_PROC;
            acc_num  <= cw_pnum;
            acc_data <= cw_data;
            ack_cnt  <= 16'(ACK_CYCLES - 1);
          end else if (enable_op && state != rf_pkg::ST_OPER) begin
            if (bad_param) begin
              state     <= rf_pkg::ST_MALF;
              malf_code <= rf_pkg::MF_BAD_PARAM;
              echo_num  <= 4'h0;
            end else begin
              state     <= rf_pkg::ST_APPLY;
              apply_idx <= 5'h00;
            end
          end else if (state == rf_pkg::ST_MALF && ext_rise
                       && cfg_o.ext_in_fn == rf_pkg::EXT_QUIT) begin
            state     <= rf_pkg::ST_OPER;
            malf_code <= rf_pkg::MF_NONE;
          end
        end
        rf_pkg::ST_PROC: begin
          if (ack_cnt == 16'h0000) begin
            state     <= rf_pkg::ST_PARAM;
            echo_num  <= acc_num;
            echo_data <= acc_data;
          end else begin
            ack_cnt <= ack_cnt - 16'h0001;
          end
        end
        rf_pkg::ST_APPLY: begin
          // one read per entry, data one cycle behind the address
          if (apply_idx == 5'h11) begin
            state     <= rf_pkg::ST_OPER;
            echo_num  <= 4'h0;
            malf_code <= rf_pkg::MF_NONE;
          end else begin
            apply_idx <= apply_idx + 5'h01;
          end
        end
        default: state <= rf_pkg::ST_OPER;
      endcase
    end
  end

  // pending bookkeeping; a write in the clearing cycle is kept
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dirty       <= 16'h0000;
      bad_param   <= 1'b0;
      apply_vld   <= 1'b0;
      apply_idx_d <= 4'h0;
    end else if (en_i) begin
      apply_vld   <= state == rf_pkg::ST_APPLY && apply_idx < 5'h10;
      apply_idx_d <= apply_idx[3:0];
      if (state == rf_pkg::ST_APPLY && apply_idx == 5'h11) begin
        dirty <= 16'h0000;
      end else if (enable_op && bad_param && state != rf_pkg::ST_OPER && !accept) begin
        dirty     <= 16'h0000;
        bad_param <= 1'b0;
      end
      if (accept) begin
        dirty[cw_pnum] <= 1'b1;
        if (!param_ok(cw_pnum, cw_data)) begin
          bad_param <= 1'b1;
        end
      end
    end
  end

  // applied configuration
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_o          <= rf_pkg::CFG_RESET;
      save_req_o     <= 1'b0;
      preset_clear_o <= 1'b0;
    end else if (en_i) begin
      save_req_o     <= 1'b0;
      preset_clear_o <= 1'b0;
      if (applying) begin
        case (apply_idx_d)
          rf_pkg::PN_RES:       cfg_o.resolution   <= rd_data[2:0];
          rf_pkg::PN_LASER_OFF: cfg_o.laser_on     <= 1'b0;
          rf_pkg::PN_LASER_ON:  cfg_o.laser_on     <= 1'b1;
          rf_pkg::PN_PRESET:    cfg_o.preset       <= rd_data;
          rf_pkg::PN_AUTO_OFF:  cfg_o.auto_off     <= rd_data[0];
          rf_pkg::PN_COUNT_DIR: cfg_o.count_down   <= rd_data[0];
          rf_pkg::PN_SPEED:     cfg_o.speed_limit  <= rd_data[7:0];
          rf_pkg::PN_BEAM_ERR:  cfg_o.beam_mode    <= rd_data[1:0];
          rf_pkg::PN_EXT_IN:    cfg_o.ext_in_fn    <= rd_data[1:0];
          rf_pkg::PN_CLR_PRE: begin
            cfg_o.clear_preset <= rd_data[0];
            preset_clear_o     <= rd_data[0];
          end
          rf_pkg::PN_EXT_OUT:   cfg_o.ext_out_fn   <= rd_data[2:0];
          rf_pkg::PN_SAVE:      save_req_o         <= 1'b1;
          default:              cfg_o.laser_on     <= cfg_o.laser_on;
        endcase
      end else if (cfg_o.auto_off && idle_cnt >= IDLE_OFF_CYCLES) begin
        cfg_o.laser_on <= 1'b0;
      end
    end
  end

  // bus idle timer for the automatic laser switch-off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_cnt <= 35'h0_0000_0000;
    end else if (en_i) begin
      if (pd_out_valid_i) begin
        idle_cnt <= 35'h0_0000_0000;
      end else if (idle_cnt < IDLE_OFF_CYCLES) begin
        idle_cnt <= idle_cnt + 35'h0_0000_0001;
      end
    end
  end

  // external input, preset load and laser enable
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_q         <= 1'b0;
      preset_load_o <= 1'b0;
      laser_en_o    <= 1'b1;
    end else if (en_i) begin
      ext_q         <= ext_in_i;
      preset_load_o <= !cfg_o.clear_preset && (zero_rise ||
                       (ext_rise && cfg_o.ext_in_fn == rf_pkg::EXT_PRESET));
      laser_en_o    <= cfg_o.laser_on &&
                       !(ext_in_i && cfg_o.ext_in_fn == rf_pkg::EXT_LOFF);
    end
  end

  // process data toward the master
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_pos            <= 25'h000_0000;
      pd_in_o             <= 32'h0000_0000;
      sensor_state_word_o <= 16'h0000;
    end else if (en_i) begin
      if (!meas_i.beam_lost) begin
        last_pos <= position_i;
      end
      case (state)
        rf_pkg::ST_PROC, rf_pkg::ST_PARAM, rf_pkg::ST_APPLY: begin
          sensor_state_word_o <= {2'b11, 1'b0, echo_num, 9'h000};
        end
        rf_pkg::ST_MALF: begin
          sensor_state_word_o <= {2'b10, 1'b0, malf_code, 9'h000};
        end
        default: begin
          if (live_code != rf_pkg::MF_NONE) begin
            sensor_state_word_o <= {2'b10, 1'b0, live_code, 9'h000};
          end else begin
            sensor_state_word_o <= 16'h0000;
          end
        end
      endcase
      pd_in_o[rf_pkg::CH_W-1:rf_pkg::CH_PNUM_LO] <=
        sensor_state_word_o[rf_pkg::ST_W-1:rf_pkg::ST_CODE_LO];
      if (state == rf_pkg::ST_PARAM) begin
        pd_in_o[rf_pkg::CH_DATA_HI:0] <= echo_data;
      end else if (state == rf_pkg::ST_PROC) begin
        pd_in_o[rf_pkg::CH_DATA_HI:0] <= rf_pkg::DATA_ZERO;
      end else if (meas_i.beam_lost) begin
        case (cfg_o.beam_mode)
          rf_pkg::BEAM_NULL: pd_in_o[rf_pkg::CH_DATA_HI:0] <= rf_pkg::DATA_ZERO;
          rf_pkg::BEAM_ONES: pd_in_o[rf_pkg::CH_DATA_HI:0] <= rf_pkg::DATA_ONES;
          default:           pd_in_o[rf_pkg::CH_DATA_HI:0] <= last_pos;
        endcase
      end else begin
        pd_in_o[rf_pkg::CH_DATA_HI:0] <= position_i;
      end
    end
  end
endmodule : rangefinder_param_status_handshake

// File: verification/rf_status_checker.sv
`timescale 1ns/1ps
module rf_status_checker #(
  parameter int          ACK_CYCLES      = 2,
  parameter logic [34:0] IDLE_OFF_CYCLES = 35'h64
) (
  input wire logic         clk_i,
  input wire logic         arst_n_i,
  input wire logic [31:0]  pd_out_i,
  input wire logic         pd_out_valid_i,
  input wire logic [31:0]  pd_in_o,
  input wire logic [15:0]  sensor_state_word_o,
  input wire rf_pkg::cfg_t cfg_o,
  input wire logic         preset_load_o
);
  // echo lands a few cycles past the acknowledge delay
  localparam int ECHO_MAX = ACK_CYCLES + 10;
  logic [15:0] w;
  assign w = sensor_state_word_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_req;
    pd_out_valid_i && pd_out_i[28:25] != 4'h0 && !pd_out_i[31] && w == 16'h0000;
  endsequence
  sequence s_enop;
    pd_out_valid_i && !pd_out_i[31] ##1 pd_out_valid_i && pd_out_i[31:25] == 7'h40;
  endsequence
  sequence s_zero;
    pd_out_valid_i && !pd_out_i[30] ##1 pd_out_valid_i && pd_out_i[30];
  endsequence
  AST_STATE: assert property (w[15:14] != 2'b01)
    else $error("state bits show 01");
  AST_OPER: assert property (w[15:14] == 2'b00 |-> w[12:9] == 4'h0)
    else $error("operation with nonzero number field");
  AST_RSVD: assert property (w[13] == 1'b0 && w[8:0] == 9'h000)
    else $error("reserved status bits set");
  AST_MAP: assert property (pd_in_o[31:25] == $past(w[15:9]))
    else $error("channel bits 31..25 differ from status word");
  AST_MALF: assert property (w[15:14] == 2'b10 |->
    w[12:9] inside {4'h1, 4'h3, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF})
    else $error("undefined malfunction code");
  AST_ACCEPT: assert property (s_req |-> ##[1:4] w[15:14] == 2'b11)
    else $error("parameter request not taken");
  AST_ECHO: assert property (s_req |-> ##[3:ECHO_MAX] w[12:9] == pd_out_i[28:25])
    else $error("parameter number not echoed");
  AST_APPLY: assert property (s_enop ##0 w[15:14] == 2'b11 |-> ##[1:30] !w[14])
    else $error("enable operation did not leave parameterization");
  AST_ZERO: assert property (s_zero ##0 (w == 16'h0000 && !cfg_o.clear_preset)
    |-> ##[1:3] preset_load_o)
    else $error("set zero edge gave no preset load");
endmodule : rf_status_checker

bind rangefinder_param_status_handshake rf_status_checker #(
  .ACK_CYCLES(ACK_CYCLES), .IDLE_OFF_CYCLES(IDLE_OFF_CYCLES)) rf_status_checker_i (
  .clk_i, .arst_n_i, .pd_out_i, .pd_out_valid_i, .pd_in_o, .sensor_state_word_o,
  .cfg_o, .preset_load_o);

// File: verification/rf_master_model.sv
`timescale 1ns/1ps
module rf_master_model (
  input  wire logic        clk_i,
  input  wire logic        send_i,
  input  wire logic [3:0]  pnum_i,
  input  wire logic [24:0] data_i,
  input  wire logic        enop_i,
  input  wire logic        zero_i,
  output logic      [31:0] pd_out_o,
  output logic             pd_out_valid_o
);
  initial begin
    pd_out_o = 32'h0000_0000;
    pd_out_valid_o = 1'b0;
  end
  always @(negedge clk_i) begin
    pd_out_valid_o <= send_i;
    // idle cycles carry a moving pattern so a stale word is never mistaken for data
    if (!send_i) pd_out_o <= ~pd_out_o;
    else pd_out_o <= {enop_i, zero_i, 1'b0, pnum_i,
                      (pnum_i == 4'hF) ? 25'h000_0000 : data_i};
  end
endmodule : rf_master_model

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                clk_i = 1'b0;
  logic                arst_n_i = 1'b0;
  logic                send = 1'b0;
  logic                enop = 1'b0;
  logic                zero = 1'b0;
  logic                ext = 1'b0;
  logic [3:0]          pnum = 4'h0;
  logic [24:0]         data = 25'h000_0000;
  rf_pkg::meas_flags_t meas = '0;
  logic [31:0]         pd_out, pd_in;
  logic [15:0]         word;
  logic                pd_valid, laser_en, pload, pclr, save;
  logic [2:0]          seen;
  rf_pkg::cfg_t        cfg;
  logic [3:0]          codes [6] = '{4'h3, 4'hE, 4'hC, 4'hD, 4'hF, 4'h9};
  logic [3:0]          pns [7] = '{4'h9, 4'hA, 4'hC, 4'hE, 4'h5, 4'h2, 4'h3};
  logic [24:0]         dvs [7] = '{25'hC8, 25'h2, 25'h1, 25'h6, 25'h1, 25'h0, 25'h0};
  int                  n_errors = 0;
  int                  samples_checked = 0;
  initial forever #25 clk_i = ~clk_i;
  rf_master_model rf_master_model_i (.clk_i, .send_i(send), .pnum_i(pnum), .data_i(data),
    .enop_i(enop), .zero_i(zero), .pd_out_o(pd_out), .pd_out_valid_o(pd_valid));
  rangefinder_param_status_handshake #(.ACK_CYCLES(2), .IDLE_OFF_CYCLES(35'h64))
    rangefinder_param_status_handshake_i (.clk_i, .arst_n_i, .en_i(1'b1), .pd_out_i(pd_out),
    .pd_out_valid_i(pd_valid), .position_i(25'h012_3456), .meas_i(meas), .ext_in_i(ext),
    .pd_in_o(pd_in), .sensor_state_word_o(word), .cfg_o(cfg), .laser_en_o(laser_en),
    .preset_load_o(pload), .preset_clear_o(pclr), .save_req_o(save));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [63:0] seen_v, input logic [63:0] exp);
    samples_checked++;
    if (seen_v !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask : chk
  // pulses last one cycle, so they are gathered while waiting
  task automatic wait_word(input logic [15:0] exp);
    seen = '0;
    for (int i = 0; i < 60 && word !== exp; i++) begin
      @(negedge clk_i);
      seen |= {save, pclr, pload};
    end
    chk("state word", 64'(word), 64'(exp));
    if (word !== exp) report_and_stop();
  endtask : wait_word
  task automatic send_param(input logic [3:0] p, input logic [24:0] d);
    enop <= 1'b0;
    pnum <= p;
    data <= d;
    wait_word({3'b110, p, 9'h000});
    @(negedge clk_i);
    chk("echo", 64'(pd_in), 64'({3'b110, p, d}));
  endtask : send_param
  task automatic enable_op(input logic [15:0] exp);
    enop <= 1'b0;
    pnum <= 4'h0;
    data <= 25'h000_0000;
    @(negedge clk_i);
    enop <= 1'b1;
    wait_word(exp);
  endtask : enable_op
  task automatic zero_rise(input logic exp, input logic on_ext);
    seen = '0;
    zero <= !on_ext;
    ext  <= on_ext;
    repeat (6) begin
      @(negedge clk_i);
      seen[0] |= pload;
    end
    zero <= 1'b0;
    ext  <= 1'b0;
    chk("zero load", 64'(seen[0]), 64'(exp));
  endtask : zero_rise
  initial begin
    repeat (10) @(negedge clk_i);
    arst_n_i <= 1'b1;
    send <= 1'b1;
    chk("reset word", 64'(word), 64'h0);
    chk("reset cfg", 64'(cfg), 64'(rf_pkg::CFG_RESET));
    send_param(rf_pkg::PN_RES, 25'h2);
    chk("pending", 64'(cfg.resolution), 64'h1);
    send_param(rf_pkg::PN_COUNT_DIR, 25'h1);
    enable_op(16'h0000);
    chk("res", 64'(cfg.resolution), 64'h2);
    chk("dir", 64'(cfg.count_down), 64'h1);
    for (int i = 0; i < 7; i++) send_param(pns[i], dvs[i]);
    enable_op(16'h0000);
    chk("speed", 64'(cfg.speed_limit), 64'hC8);
    chk("beam", 64'(cfg.beam_mode), 64'h2);
    chk("ext in", 64'(cfg.ext_in_fn), 64'h1);
    chk("ext out", 64'(cfg.ext_out_fn), 64'h6);
    chk("auto off", 64'(cfg.auto_off), 64'h1);
    chk("laser", 64'(laser_en), 64'h1);
    zero_rise(1'b1, 1'b0);
    zero_rise(1'b1, 1'b1);
    send_param(rf_pkg::PN_SAVE, 25'h0);
    enable_op(16'h0000);
    chk("save", 64'(seen[2]), 64'h1);
    send_param(rf_pkg::PN_CLR_PRE, 25'h1);
    enable_op(16'h0000);
    chk("clear", 64'(seen[1]), 64'h1);
    zero_rise(1'b0, 1'b0);
    zero_rise(1'b0, 1'b1);
    send_param(rf_pkg::PN_UNDEF6, 25'h0);
    send_param(rf_pkg::PN_SPEED, 25'hC9);
    enable_op({3'b100, rf_pkg::MF_BAD_PARAM, 9'h000});
    enable_op(16'h0000);
    for (int i = 0; i < 6; i++) begin
      meas <= 6'b10_0000 >> i;
      wait_word({3'b100, codes[i], 9'h000});
      chk("position", 64'(pd_in[24:0]), 64'h0012_3456);
      meas <= '0;
      wait_word(16'h0000);
    end
    send_param(rf_pkg::PN_LASER_OFF, 25'h0);
    enable_op({3'b100, rf_pkg::MF_LASER_OFF, 9'h000});
    chk("laser", 64'(laser_en), 64'h0);
    send_param(rf_pkg::PN_LASER_ON, 25'h0);
    enable_op(16'h0000);
    send <= 1'b0;
    repeat (110) @(negedge clk_i);
    chk("idle off", 64'(laser_en), 64'h0);
    report_and_stop();
  end
endmodule : testbench
